// [inc/pssm_defs.vh]
// Purpose: constants for the servo status monitor
// Assumes: byte addresses on a 32-bit AXI4-Lite bus
// Notes:   all offsets are word aligned
`ifndef PSSM_DEFS_VH
`define PSSM_DEFS_VH
// Register byte offsets
`define PSSM_A_MODE      8'h00
`define PSSM_A_STEP      8'h04
`define PSSM_A_STATUS    8'h08
`define PSSM_A_EVENT     8'h0c
`define PSSM_A_ID_LO     8'h10
`define PSSM_A_ID_HI     8'h14
`define PSSM_A_OFS_LO    8'h18
`define PSSM_A_OFS_HI    8'h1c
// Reset values
`define PSSM_MODE_RST    2'h1
`define PSSM_STEP_RST    3'h0
// Protocol modes
`define PSSM_MODE_OFF    2'h0
`define PSSM_MODE_AUTO   2'h1
`define PSSM_MODE_SLAVE  2'h2
// Servo state codes
`define PSSM_SV_UNLOCKED 2'h0
`define PSSM_SV_SYNC     2'h1
`define PSSM_SV_LOCKED   2'h2
`define PSSM_SV_VOID     2'h3
// Port event codes
`define PSSM_EV_NONE     4'h0
`define PSSM_EV_PWRUP    4'h1
`define PSSM_EV_INIT     4'h2
`define PSSM_EV_DES_ON   4'h3
`define PSSM_EV_DES_OFF  4'h4
`define PSSM_EV_FLT_CLR  4'h5
`define PSSM_EV_FLT_SET  4'h6
`define PSSM_EV_STATE    4'h7
`define PSSM_EV_QUAL     4'h8
`define PSSM_EV_ANNOUNCE 4'h9
`define PSSM_EV_SYNCFLT  4'ha
`define PSSM_EV_CHOSEN   4'hb
`define PSSM_EV_RS_M     4'hc
`define PSSM_EV_RS_GM    4'hd
`define PSSM_EV_RS_S     4'he
`define PSSM_EV_RS_P     4'hf
// Step limit selector and thresholds in microseconds
`define PSSM_STEP_10     3'h0
`define PSSM_STEP_20     3'h1
`define PSSM_STEP_100    3'h2
`define PSSM_STEP_500    3'h3
`define PSSM_STEP_1000   3'h4
`define PSSM_STEP_2000   3'h5
`define PSSM_US_10       64'd10
`define PSSM_US_20       64'd20
`define PSSM_US_100      64'd100
`define PSSM_US_500      64'd500
`define PSSM_US_1000     64'd1000
`define PSSM_US_2000     64'd2000
`define PSSM_NS_PER_US   64'd1000
// EUI-64 filler between MAC halves
`define PSSM_EUI_FILL    16'hfffe
// AXI responses
`define PSSM_RESP_OKAY   2'h0
`define PSSM_RESP_SLVERR 2'h2
`endif

// [hw/pssm_servo_status.v]
// Purpose: servo state, master identity, offset and event log behind AXI4-Lite
// Assumes: all inputs synchronous to aclk; offset is two's complement ns
// Notes:   offset registers latch high word when low word is read
//
// Functional notes
// - Report unlocked while servo is not yet ready to track master.
// - Report synchronizing while unlocked and converging toward the master.
// - Report locked while servo is syntonizing to the master.
// - Report not-applicable when servo state has no meaning.
// - Master identity is MAC upper half, 0xfffe, MAC lower half.
// - Current offset always available as a 64-bit nanosecond value.
// - Measured offset is passed to the servo as correction input.
// - Last-event field holds the newest port state-change event.
// - Last-event codes cover none through recommended-state passive.
// - Offset magnitude beyond step limit unlocks servo, restarts adjustment.
// - Step limit selectable as 10, 20, 100, 500, 1000 or 2000 us.
// - Mode off disables time-protocol operation entirely.
// - In slave port state the clock synchronizes to the master.
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "pssm_defs.vh"
`timescale 1ns/100ps
`default_nettype none
module pssm_servo_status (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        port_is_slave,
  input  wire [47:0] master_mac,
  input  wire [63:0] offset_ns,
  input  wire        offset_valid,
  input  wire [3:0]  port_event,
  input  wire        port_event_valid,
  output wire        ptp_enable,
  output reg  [63:0] servo_offset,
  output reg         servo_offset_valid,
  output reg         servo_restart,
  output reg  [1:0]  servo_lock_state
);

////////////////////////////////////////////////////////////////////////////////
// Servo states, one-hot
localparam [3:0] ST_VOID     = 4'h1;
localparam [3:0] ST_UNLOCKED = 4'h2;
localparam [3:0] ST_SYNC     = 4'h4;
localparam [3:0] ST_LOCKED   = 4'h8;

reg  [1:0]  mode;
reg  [2:0]  servo_step_limit;
reg  [3:0]  last_port_event;
reg  [63:0] best_master_identity;
reg  [63:0] master_offset_nanoseconds;
reg  [31:0] ofs_hi_shadow;
reg  [3:0]  state;
reg  [3:0]  next_state;
reg  [63:0] limit_ns;
wire        active;
wire [63:0] offset_abs;
wire        over_limit;

////////////////////////////////////////////////////////////////////////////////
// Operating qualifier
assign ptp_enable = (mode != `PSSM_MODE_OFF);
assign active     = ptp_enable && port_is_slave;

////////////////////////////////////////////////////////////////////////////////
// Step limit in nanoseconds
always @* begin
  case (servo_step_limit)
    `PSSM_STEP_10:   limit_ns = `PSSM_US_10 * `PSSM_NS_PER_US;
    `PSSM_STEP_20:   limit_ns = `PSSM_US_20 * `PSSM_NS_PER_US;
    `PSSM_STEP_100:  limit_ns = `PSSM_US_100 * `PSSM_NS_PER_US;
    `PSSM_STEP_500:  limit_ns = `PSSM_US_500 * `PSSM_NS_PER_US;
    `PSSM_STEP_1000: limit_ns = `PSSM_US_1000 * `PSSM_NS_PER_US;
    `PSSM_STEP_2000: limit_ns = `PSSM_US_2000 * `PSSM_NS_PER_US;
    default:         limit_ns = `PSSM_US_10 * `PSSM_NS_PER_US;
  endcase
end

// Most negative offset maps to itself, still far above any limit
assign offset_abs = offset_ns[63] ? (~offset_ns + 64'h1) : offset_ns;
assign over_limit = (offset_abs > limit_ns);

////////////////////////////////////////////////////////////////////////////////
// Servo state machine
always @* begin
  next_state = state;
  case (state)
    ST_VOID: begin
      if (active) begin
        next_state = ST_UNLOCKED;
      end
    end
    ST_UNLOCKED: begin
      // First offset sample within the step limit means the servo can start converging
      if (offset_valid) begin
        next_state = over_limit ? ST_UNLOCKED : ST_SYNC;
      end
    end
    ST_SYNC: begin
      if (offset_valid) begin
        next_state = over_limit ? ST_UNLOCKED : ST_LOCKED;
      end
    end
    ST_LOCKED: begin
      if (offset_valid && over_limit) begin
        next_state = ST_UNLOCKED;
      end
    end
    default: begin
      next_state = ST_VOID;
    end
  endcase
  if (!active) begin
    next_state = ST_VOID;
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    state <= ST_VOID;
  end else begin
    state <= next_state;
  end
end

always @(posedge aclk) begin
  if (!aresetn) begin
    servo_lock_state <= `PSSM_SV_VOID;
  end else begin
    case (next_state)
      ST_UNLOCKED: servo_lock_state <= `PSSM_SV_UNLOCKED;
      ST_SYNC:     servo_lock_state <= `PSSM_SV_SYNC;
      ST_LOCKED:   servo_lock_state <= `PSSM_SV_LOCKED;
      default:     servo_lock_state <= `PSSM_SV_VOID;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Offset path into the servo
always @(posedge aclk) begin
  if (!aresetn) begin
    master_offset_nanoseconds <= 64'h0;
    servo_offset              <= 64'h0;
    servo_offset_valid        <= 1'b0;
    servo_restart             <= 1'b0;
  end else begin
    servo_offset_valid <= 1'b0;
    servo_restart      <= 1'b0;
    if (active && offset_valid) begin
      master_offset_nanoseconds <= offset_ns;
      servo_offset              <= offset_ns;
      servo_offset_valid        <= 1'b1;
      // Restart only from a tracking state, not while already unlocked,
      // nor on the first sample seen while still leaving the void state
      servo_restart <= over_limit && ((state == ST_SYNC) || (state == ST_LOCKED));
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Master identity and event log
always @(posedge aclk) begin
  if (!aresetn) begin
    best_master_identity <= 64'h0;
    last_port_event      <= `PSSM_EV_NONE;
  end else begin
    if (ptp_enable) begin
      best_master_identity <= {master_mac[47:24], `PSSM_EUI_FILL, master_mac[23:0]};
    end
    if (ptp_enable && port_event_valid) begin
      last_port_event <= port_event;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite write channel
reg        aw_held;
reg [7:0]  aw_addr;
reg        w_held;
reg [31:0] w_data;
reg [3:0]  w_strb;
wire       wr_go;

// Pending response blocks the next write, so one write at a time
assign s_axi_awready = !aw_held;
assign s_axi_wready  = !w_held;
assign wr_go         = aw_held && w_held && !s_axi_bvalid;

always @(posedge aclk) begin
  if (!aresetn) begin
    aw_held          <= 1'b0;
    aw_addr          <= 8'h0;
    w_held           <= 1'b0;
    w_data           <= 32'h0;
    w_strb           <= 4'h0;
    s_axi_bvalid     <= 1'b0;
    s_axi_bresp      <= `PSSM_RESP_OKAY;
    mode             <= `PSSM_MODE_RST;
    servo_step_limit <= `PSSM_STEP_RST;
  end else begin
    if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
    if (wr_go) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= `PSSM_RESP_OKAY;
      case (aw_addr)
        `PSSM_A_MODE: begin
          if (w_strb[0]) begin
            mode <= w_data[1:0];
          end
        end
        `PSSM_A_STEP: begin
          // Codes beyond the six settings are refused, limit unchanged
          if (w_strb[0] && (w_data[2:0] <= `PSSM_STEP_2000)) begin
            servo_step_limit <= w_data[2:0];
          end
        end
        // Status words are read-only; writes are absorbed
        `PSSM_A_STATUS, `PSSM_A_EVENT, `PSSM_A_ID_LO, `PSSM_A_ID_HI,
        `PSSM_A_OFS_LO, `PSSM_A_OFS_HI: begin
          s_axi_bresp <= `PSSM_RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= `PSSM_RESP_SLVERR;
        end
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite read channel
// Read data registered; no new address while a response waits
assign s_axi_arready = !s_axi_rvalid;

always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_rvalid  <= 1'b0;
    s_axi_rdata   <= 32'h0;
    s_axi_rresp   <= `PSSM_RESP_OKAY;
    ofs_hi_shadow <= 32'h0;
  end else begin
    if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
    if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `PSSM_RESP_OKAY;
      case (s_axi_araddr)
        `PSSM_A_MODE:   s_axi_rdata <= {30'h0, mode};
        `PSSM_A_STEP:   s_axi_rdata <= {29'h0, servo_step_limit};
        `PSSM_A_STATUS: s_axi_rdata <= {28'h0, port_is_slave, ptp_enable, servo_lock_state};
        `PSSM_A_EVENT:  s_axi_rdata <= {28'h0, last_port_event};
        `PSSM_A_ID_LO:  s_axi_rdata <= best_master_identity[31:0];
        `PSSM_A_ID_HI:  s_axi_rdata <= best_master_identity[63:32];
        `PSSM_A_OFS_LO: begin
          // Low word read freezes the high half for a coherent pair
          s_axi_rdata   <= master_offset_nanoseconds[31:0];
          ofs_hi_shadow <= master_offset_nanoseconds[63:32];
        end
        `PSSM_A_OFS_HI: s_axi_rdata <= ofs_hi_shadow;
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `PSSM_RESP_SLVERR;
        end
      endcase
    end
  end
end

endmodule
`default_nettype wire

// [testbench/pssm_servo_status_monitor.sv]
// Purpose: servo side assertions
// Assumes: one clock, sync reset
// Notes:   bus side judged by bench
`timescale 1ns/100ps
`default_nettype none
module pssm_servo_status_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        port_is_slave,
  input wire logic [63:0] offset_ns,
  input wire logic        offset_valid,
  input wire logic        ptp_enable,
  input wire logic [63:0] servo_offset,
  input wire logic        servo_offset_valid,
  input wire logic        servo_restart,
  input wire logic [1:0]  servo_lock_state
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic act = ptp_enable && port_is_slave;
  wire logic sv = servo_offset_valid;
  wire logic [1:0] st = servo_lock_state;
  sequence s_in; act && offset_valid; endsequence
  sequence s_out; sv && servo_offset == $past(offset_ns); endsequence
  a_offset_fed: assert property (s_in |=> s_out)
    else $error("offset not fed");
  a_void_idle: assert property (!act |=> st == 2'h3)
    else $error("state not void");
  a_no_stray: assert property (!offset_valid |=> !sv)
    else $error("stray offset pulse");
  a_restart_why: assert property (servo_restart |-> sv && st == 2'h0 &&
    $past(st) inside {2'h1, 2'h2}) else $error("bad restart");
  a_no_skip: assert property (sv && $past(st) == 2'h0 |-> st != 2'h2)
    else $error("lock skipped sync");
  a_lock_step: assert property (sv && !servo_restart &&
    $past(st) inside {2'h1, 2'h2} |-> st == 2'h2) else $error("no lock");
  a_hold_state: assert property (act && !offset_valid && st != 2'h3 |=> $stable(st))
    else $error("state moved idle");
  a_wake_unlocked: assert property (act && !offset_valid && st == 2'h3 |=> st == 2'h0)
    else $error("no unlocked");
endmodule
////////////////////////////////////////
bind pssm_servo_status pssm_servo_status_monitor u_mon (.aclk, .aresetn, .port_is_slave,
  .offset_ns, .offset_valid, .ptp_enable, .servo_offset, .servo_offset_valid,
  .servo_restart, .servo_lock_state);
`default_nettype wire

// [testbench/pssm_master_model.sv]
// Purpose: network master clock model
// Assumes: drives just after rising edges
// Notes:   released data shows inverse
`timescale 1ns/100ps
`default_nettype none
module pssm_master_model #(parameter logic [47:0] MAC = 48'h0) (
  input  wire logic        aclk,
  output var  logic [47:0] master_mac = MAC,
  output var  logic [63:0] offset_ns = 64'h0,
  output var  logic        offset_valid = 1'b0,
  output var  logic [3:0]  port_event = 4'h0,
  output var  logic        port_event_valid = 1'b0
);
  task automatic send_offset(input logic [63:0] v);
    @(posedge aclk);
    offset_ns <= v;
    offset_valid <= 1'b1;
    @(posedge aclk);
    offset_ns <= ~v;
    offset_valid <= 1'b0;
  endtask
  task automatic send_event(input logic [3:0] c);
    @(posedge aclk);
    port_event <= c;
    port_event_valid <= 1'b1;
    @(posedge aclk);
    port_event <= ~c;
    port_event_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [testbench/pssm_servo_status_tb_top.sv]
// Purpose: self-checking bench
// Assumes: 20 MHz clock
// Notes:   one task per scenario
`timescale 1ns/100ps
`default_nettype none
`include "pssm_defs.vh"
module pssm_servo_status_tb_top;
  localparam logic [47:0] MAC = 48'h02a4c6e81357; // Arbitrary value
  localparam logic [63:0] EID = {MAC[47:24], `PSSM_EUI_FILL, MAC[23:0]};
  logic aclk = 1'b0, aresetn = 1'b0, port_is_slave = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic ptp_enable, servo_offset_valid, servo_restart, offset_valid, port_event_valid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp, servo_lock_state;
  wire logic [31:0] s_axi_rdata;
  wire logic [47:0] master_mac;
  wire logic [63:0] offset_ns, servo_offset;
  wire logic [3:0] port_event;
  int bad_count = 0;
  int total_checks = 0;
  always #25 aclk = ~aclk;
  pssm_servo_status DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .port_is_slave, .master_mac, .offset_ns, .offset_valid,
    .port_event, .port_event_valid, .ptp_enable, .servo_offset, .servo_offset_valid,
    .servo_restart, .servo_lock_state);
  pssm_master_model #(.MAC(MAC)) u_master (.aclk, .master_mac, .offset_ns, .offset_valid,
    .port_event, .port_event_valid);
////////////////////////////////////////
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && ++n < 40);
    chk(s_axi_bvalid, 1'b1);
    if (!s_axi_bvalid) conclude();
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && ++n < 40);
    chk(s_axi_rvalid, 1'b1);
    if (!s_axi_rvalid) conclude();
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask
  task automatic step(input logic [63:0] v, input logic [1:0] s, input logic x);
    u_master.send_offset(v);
    #1;
    chk(servo_lock_state, s);
    chk(servo_restart, x);
    chk(servo_offset, v);
    chk(servo_offset_valid, 1'b1);
  endtask
  task automatic t_reset();
    rd(`PSSM_A_STATUS, 32'h7);
    rd(`PSSM_A_EVENT, 32'h0);
    rd(8'h20, 32'h0, `PSSM_RESP_SLVERR);
    wr(8'h20, 32'h1, `PSSM_RESP_SLVERR);
    rd(`PSSM_A_ID_LO, EID[31:0]);
    rd(`PSSM_A_ID_HI, EID[63:32]);
  endtask
  task automatic t_offset();
    port_is_slave <= 1'b1;
    repeat (2) @(posedge aclk);
    #1;
    chk(servo_lock_state, `PSSM_SV_UNLOCKED);
    step(64'h8765432112345678, `PSSM_SV_UNLOCKED, 1'b0);
    rd(`PSSM_A_OFS_LO, 32'h12345678);
    rd(`PSSM_A_OFS_HI, 32'h87654321);
  endtask
  task automatic t_events();
    for (int c = 0; c < 16; c++) begin
      u_master.send_event(4'(c));
      rd(`PSSM_A_EVENT, 32'(c));
    end
  endtask
  task automatic t_servo();
    logic [63:0] us [6];
    logic [63:0] lim;
    us = '{`PSSM_US_10, `PSSM_US_20, `PSSM_US_100,
      `PSSM_US_500, `PSSM_US_1000, `PSSM_US_2000};
    for (int i = 0; i < 6; i++) begin
      wr(`PSSM_A_STEP, 32'(i));
      lim = us[i] * `PSSM_NS_PER_US;
      step(lim + 64'h1, `PSSM_SV_UNLOCKED, 1'b0);
      step(lim, `PSSM_SV_SYNC, 1'b0);
      step(-lim, `PSSM_SV_LOCKED, 1'b0);
      step(-lim - 64'h1, `PSSM_SV_UNLOCKED, 1'b1);
    end
    wr(`PSSM_A_STEP, 32'h6);
    s_axi_wstrb <= 4'h0;
    wr(`PSSM_A_STEP, 32'h0);
    s_axi_wstrb <= 4'hf;
    rd(`PSSM_A_STEP, 32'h5);
    step(64'h0, `PSSM_SV_SYNC, 1'b0);
    step(lim + 64'h1, `PSSM_SV_UNLOCKED, 1'b1);
  endtask
  task automatic t_off();
    wr(`PSSM_A_MODE, 32'h0);
    chk(ptp_enable, 1'b0);
    u_master.send_event(`PSSM_EV_FLT_SET);
    #1;
    chk(servo_lock_state, `PSSM_SV_VOID);
    rd(`PSSM_A_EVENT, 32'hf);
    rd(`PSSM_A_STATUS, 32'hb);
    wr(`PSSM_A_MODE, 32'h2);
    rd(`PSSM_A_MODE, 32'h2);
    port_is_slave <= 1'b0;
    rd(`PSSM_A_STATUS, 32'h7);
    port_is_slave <= 1'b1;
    rd(`PSSM_A_STATUS, 32'hc);
  endtask
  task automatic t_rearm();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`PSSM_A_MODE, 32'(`PSSM_MODE_RST));
    rd(`PSSM_A_STEP, 32'(`PSSM_STEP_RST));
    rd(`PSSM_A_EVENT, 32'(`PSSM_EV_NONE));
  endtask
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_offset();
    t_events();
    t_servo();
    t_off();
    t_rearm();
    conclude();
  end
endmodule
`default_nettype wire
